// ---- common/sgc_regs.vh ----
/*
 * register map, field positions and reset values of the switch global
 * control and status block.
 * assumes: included by bare name; definitions only.
 */
`ifndef SGC_REGS_VH
`define SGC_REGS_VH

// register numbers (indices); byte address is four times the index
`define SGC_IDX_IDENTITY 14'h0000
`define SGC_IDX_RESET 14'h0001
`define SGC_IDX_MASK 14'h0004
`define SGC_IDX_PENDING 14'h0005
`define SGC_IDX_PORT0_VER 14'h0400
`define SGC_IDX_PORT1_VER 14'h0800
`define SGC_IDX_PORT2_VER 14'h0C00

// interrupt source bit positions in mask and pending
`define SGC_BIT_BUFMGR 6
`define SGC_BIT_ENGINE 5
`define SGC_BIT_PORT2 2
`define SGC_BIT_PORT1 1
`define SGC_BIT_PORT0 0

// reset values and bit masks
`define SGC_MASK_RESET 9'h1FF
`define SGC_MASK_RSVD_BITS 9'h198
`define SGC_PEND_IMPL_BITS 7'h67
`define SGC_RESET_BIT_RESET 1'h0

// axi responses
`define SGC_RESP_OKAY 2'h0
`define SGC_RESP_SLVERR 2'h2

`endif

// ---- design/sgc_global_csr.v ----
/*
 * switch fabric general control and status: identity, global fabric
 * reset, two-level interrupt aggregation and per-port mac version
 * registers, reached over an axi4-lite slave.
 * assumes: sub-block pending inputs are synchronous to aclk and each
 * is a level that is high while any unmasked bit of that sub-block's
 * pending register is set.
 */
`timescale 1ns/1ns
`include "sgc_regs.vh"

module sgc_global_csr #(
   parameter [7:0] DEV_TYPE = 8'h11,   // arbitrary value
   parameter [7:0] CHIP_VER = 8'h22,   // arbitrary value
   parameter [7:0] REV_CODE = 8'h33,   // arbitrary value
   parameter [3:0] PORT_DEV_TYPE = 4'h1,   // arbitrary value
   parameter [3:0] PORT_CHIP_VER = 4'h2,   // arbitrary value
   parameter [3:0] PORT_REV_CODE = 4'h4   // arbitrary value
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [15:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [15:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // sub-block interrupt levels
   input wire bufmgr_pending,
   input wire engine_pending,
   input wire port2_pending,
   input wire port1_pending,
   input wire port0_pending,
   // fabric reset and chip-level interrupt
   output reg fabric_reset,
   output reg chip_irq_status
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   reg [8:0] fabric_irq_mask_reg;
   reg [6:0] fabric_irq_pending_reg;
   reg fabric_global_reset_reg;
   reg [15:0] awaddr_reg;
   reg aw_held_reg;
   reg [31:0] wdata_reg;
   reg w_held_reg;
   // strobes are held with the data word they qualify, so a data beat
   // taken ahead of its address still lands on the lanes it named
   reg [3:0] wstrb_reg;
   wire [3:0] wr_strb;

   wire [6:0] pend_src;
   wire [6:0] irq_set;
   wire [6:0] pend_next;
   wire wr_fire;
   wire rd_fire;
   wire [13:0] wr_idx;
   wire [13:0] rd_idx;
   wire [15:0] wr_addr;
   wire [31:0] wr_data;
   reg [31:0] rd_data;
   reg rd_hit;

   function [13:0] word_index;
      input [15:0] addr;
      begin
         word_index = addr[15:2];
      end
   endfunction

   function is_port_ver;
      input [13:0] idx;
      begin
         // one layout at three bases
         is_port_ver = (idx == `SGC_IDX_PORT0_VER) ||
                       (idx == `SGC_IDX_PORT1_VER) ||
                       (idx == `SGC_IDX_PORT2_VER);
      end
   endfunction

   // ---------------------------------------------------------------
   // interrupt aggregation
   // ---------------------------------------------------------------
   assign pend_src = {bufmgr_pending, engine_pending, 2'h0,
                      port2_pending, port1_pending, port0_pending};
   // status sets regardless of the global mask
   assign irq_set = pend_src & `SGC_PEND_IMPL_BITS;
   // a source event in the read cycle wins over the read clear
   assign pend_next = (rd_fire && rd_idx == `SGC_IDX_PENDING) ?
                      irq_set :
                      (fabric_irq_pending_reg | irq_set);

   // ---------------------------------------------------------------
   // axi write path
   // ---------------------------------------------------------------
   assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
   // the protection attributes carry no meaning for this block; every
   // access is served the same way whatever they say
   assign wr_idx = word_index(wr_addr);
   assign wr_fire = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held_reg || (s_axi_wvalid && s_axi_wready)) &&
                    !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SGC_RESP_OKAY;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 16'h0000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         fabric_irq_mask_reg <= `SGC_MASK_RESET;
         fabric_global_reset_reg <= `SGC_RESET_BIT_RESET;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready &&
                          !s_axi_bvalid && !wr_fire;
         s_axi_wready <= !w_held_reg && !s_axi_wready &&
                         !s_axi_bvalid && !wr_fire;
         if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `SGC_RESP_OKAY;
            if (wr_idx == `SGC_IDX_RESET) begin
               // stays set until software writes zero
               if (wr_strb[0])
                  fabric_global_reset_reg <= wr_data[0];
            end else if (wr_idx == `SGC_IDX_MASK) begin
               // reserved bits are stored as written
               if (wr_strb[0])
                  fabric_irq_mask_reg[7:0] <= wr_data[7:0];
               if (wr_strb[1])
                  fabric_irq_mask_reg[8] <= wr_data[8];
            end else if (wr_idx == `SGC_IDX_IDENTITY ||
                         wr_idx == `SGC_IDX_PENDING ||
                         is_port_ver(wr_idx)) begin
               // read-only registers ignore writes
               s_axi_bresp <= `SGC_RESP_OKAY;
            end else begin
               s_axi_bresp <= `SGC_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // axi read path
   // ---------------------------------------------------------------
   // the read address is decoded straight from the bus; it is only
   // used in the cycle it is taken, so no copy of it is kept
   // a miss answers zero with an error code and changes nothing
   assign rd_idx = word_index(s_axi_araddr);
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always @* begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      if (rd_idx == `SGC_IDX_IDENTITY) begin
         rd_data = {8'h00, DEV_TYPE, CHIP_VER, REV_CODE};
      end else if (rd_idx == `SGC_IDX_RESET) begin
         // write-only bit reads as zero
         rd_data = 32'h0000_0000;
      end else if (rd_idx == `SGC_IDX_MASK) begin
         rd_data = {23'h000000, fabric_irq_mask_reg};
      end else if (rd_idx == `SGC_IDX_PENDING) begin
         rd_data = {25'h0000000, fabric_irq_pending_reg};
      end else if (is_port_ver(rd_idx)) begin
         rd_data = {20'h00000, PORT_DEV_TYPE, PORT_CHIP_VER,
                    PORT_REV_CODE};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SGC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_fire;
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? `SGC_RESP_OKAY : `SGC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // pending register and outputs
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         fabric_irq_pending_reg <= 7'h00;
         fabric_reset <= 1'b0;
         chip_irq_status <= 1'b0;
      end else begin
         fabric_irq_pending_reg <= pend_next;
         // held for as long as the bit stays set; one flop of delay keeps
         // the fabric reset glitch free at the cost of a cycle
         fabric_reset <= fabric_global_reset_reg;
         chip_irq_status <= |(fabric_irq_pending_reg &
                              ~fabric_irq_mask_reg[6:0] &
                              `SGC_PEND_IMPL_BITS);
      end
   end

endmodule

// ---- sim/sgc_global_csr_properties.sv ----
/* checker for the switch global csr block, bound to its top module.
   assumes: one clock, aresetn synchronous and active low. */
`timescale 1ns/1ns
// -------------------------------------
// bus and output relations
// -------------------------------------
module sgc_csr_props (
   // ports grouped several to a line to keep the checker short
   input wire aclk, input wire aresetn,
   input wire [15:0] s_axi_awaddr, input wire s_axi_awvalid,
   input wire s_axi_awready, input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb, input wire s_axi_wvalid,
   input wire s_axi_wready, input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid, input wire s_axi_bready,
   input wire [15:0] s_axi_araddr, input wire s_axi_arvalid,
   input wire s_axi_arready, input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid, input wire s_axi_rready,
   input wire fabric_reset, input wire chip_irq_status
);
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ar_to_r_a: assert property (ar_hs |=> s_axi_rvalid)
      else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   aw_to_b_a: assert property (wr_hs |=> s_axi_bvalid)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
   ident_rsvd_a: assert property (
      ar_hs && s_axi_araddr == 16'h0000 |=> s_axi_rdata[31:24] == 8'h00)
      else $error("identity top byte set");
   ver_rsvd_a: assert property (
      ar_hs && s_axi_araddr[11:0] == 12'h000 && s_axi_araddr[15:12] != 0
      |=> s_axi_rdata[31:12] == 20'h00000) else $error("version high set");
   pend_rsvd_a: assert property (ar_hs && s_axi_araddr == 16'h0014 |=>
      s_axi_rdata[31:7] == 0 && s_axi_rdata[4:3] == 0)
      else $error("pending reserved set");
   frst_set_a: assert property (wr_hs && s_axi_awaddr == 16'h0004 &&
      s_axi_wdata[0] && s_axi_wstrb[0] |-> ##[1:3] fabric_reset)
      else $error("fabric reset not applied");
   rst_val_a: assert property ($rose(aresetn) |->
      !fabric_reset && !chip_irq_status) else $error("bad reset state");
endmodule
bind sgc_global_csr sgc_csr_props u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .fabric_reset(fabric_reset), .chip_irq_status(chip_irq_status));

// ---- sim/tb_sgc_global_csr.sv ----
/* self-checking bench for the switch global csr block.
   assumes: design parameters left at their defaults. */
`timescale 1ns/1ns
`include "sgc_regs.vh"
// -------------------------------------
// bench
// -------------------------------------
module tb_sgc_global_csr;
   reg aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
   reg arv = 1'b0, rr = 1'b0;
   reg [15:0] awa = 16'h0000, ara = 16'h0000;
   reg [31:0] wd = 32'h0, seed = 32'h7172929F, d, m, p;
   reg [6:0] src = 7'h00;
   reg [1:0] r;
   wire awr, wr_rdy, bv, arr, rv, frst, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer errors = 0, n_compared = 0, cyc = 0, i;
   always #4 aclk = ~aclk;
   sgc_global_csr u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .bufmgr_pending(src[6]),
      .engine_pending(src[5]), .port2_pending(src[2]),
      .port1_pending(src[1]), .port0_pending(src[0]),
      .fabric_reset(frst), .chip_irq_status(irq));
   function [31:0] xs(input [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
   endfunction
   // only implemented sources that are unmasked reach the chip interrupt
   function [31:0] irq_exp(input [31:0] mk, input [31:0] pd);
      irq_exp = {31'h0, |(pd[6:0] & ~mk[6:0] & 7'h67)};
   endfunction
   task summarize;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input [8*5:1] nm, input [31:0] e, input [31:0] g);
      n_compared = n_compared + 1;
      if (e !== g) begin
         $display("MISMATCH %0s exp %h got %h", nm, e, g);
         errors = errors + 1;
      end
   endtask
   task wr(input [15:0] a, input [31:0] v);
      @(posedge aclk);
      awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
      end while (!bv);
      r = bresp;
      br <= 1'b0;
   endtask
   task rd(input [15:0] a);
      @(posedge aclk);
      ara <= a; arv <= 1'b1; rr <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      d = rdata;
      r = rresp;
      rr <= 1'b0;
   endtask
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc > 20000) begin
         errors = errors + 1;
         summarize;
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(16'h0000); chk("ident", 32'h00112233, d);
      wr(16'h0000, seed); rd(16'h0000); chk("ident", 32'h00112233, d);
      for (i = 1; i < 4; i = i + 1) begin
         rd(i << 12); chk("ver", 32'h124, d);
      end
      rd(16'h0010); chk("mask", 32'h1FF, d);
      rd(16'h0004); chk("rst", 32'h0, d);
      rd(16'h0014); chk("pend", 32'h0, d);
      rd(16'h0008); chk("resp", `SGC_RESP_SLVERR, {30'h0, r});
      wr(16'h0008, 32'h1); chk("resp", `SGC_RESP_SLVERR, {30'h0, r});
      wr(16'h0004, 32'h1); repeat (4) @(posedge aclk);
      chk("frst", 32'h1, {31'h0, frst});
      wr(16'h0004, 32'h0); repeat (3) @(posedge aclk);
      chk("frst", 32'h0, {31'h0, frst});
      for (i = 0; i < 20; i = i + 1) begin
         seed = xs(seed);
         m = (i == 0) ? 32'h198 : (seed & 32'h67) | 32'h198;
         seed = xs(seed);
         p = (i == 0) ? 32'h67 : seed & 32'h67;
         wr(16'h0010, m);
         @(posedge aclk) src <= p[6:0];
         @(posedge aclk) src <= 7'h00;
         repeat (3) @(posedge aclk);
         chk("irq", irq_exp(m, p), {31'h0, irq});
         rd(16'h0014); chk("pend", p, d);
         rd(16'h0014); chk("pend", 32'h0, d);
         rd(16'h0010); chk("mask", m, d);
      end
      // a source still high at the clearing read sets the bit again
      src <= 7'h01;
      rd(16'h0014); chk("pend", 32'h1, d);
      rd(16'h0014); chk("pend", 32'h1, d);
      src <= 7'h00;
      rd(16'h0014); chk("pend", 32'h1, d);
      rd(16'h0014); chk("pend", 32'h0, d);
      // reset in mid-run restores mask and pending defaults
      wr(16'h0010, 32'h198); src <= 7'h20;
      @(posedge aclk) aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1; src <= 7'h00;
      rd(16'h0010); chk("mask", 32'h1FF, d);
      rd(16'h0014); chk("pend", 32'h0, d);
      chk("irq", 32'h0, {31'h0, irq});
      summarize;
   end
endmodule
